// File: verilog/rx_obs_cfg.svh
`ifndef RX_OBS_CFG_SVH
`define RX_OBS_CFG_SVH

// ============================================================
// Observation bus layout
// ============================================================
`define OBS_WIDTH        39
`define OBS_SEQ_LSB      0
`define OBS_SEQ_W        3
`define OBS_CHK_LSB      3
`define OBS_CHK_W        8
`define OBS_VC_LSB       11
`define OBS_VC_W         3
`define OBS_HI_LSB       14
`define OBS_HI_W         24
`define OBS_OK_BIT       38

// ============================================================
// Check-state bit positions
// ============================================================
`define CHK_LCRC_CHECK   0
`define CHK_LCRC_ERR     1
`define CHK_END_LEN      2
`define CHK_FORM         3
`define CHK_FC_OVF       4
`define CHK_ECRC         5
`define CHK_UNSUP        6
`define CHK_CFG          7

// ============================================================
// Test-in control bits
// ============================================================
`define TI_WIDTH         8
`define TI_INJ_LCRC      0
`define TI_INJ_ECRC      1
`define TI_FORCE_COMPL   2
`define TI_DIS_COMPL     3
`define TI_REMOTE_BOOT   4
`define TI_CLR_COUNT     5

// ============================================================
// Counters and reset values
// ============================================================
`define ERR_CNT_W        16
`define ERR_TYPES        6
`define TC_W             3
`define TC_MAP_W         24
`define OBS_RESET        39'h00_0000_0000

`endif

// File: verilog/rx_obs_pkg.sv
`include "rx_obs_cfg.svh"

package rx_obs_pkg;

   // Buffer side-effect sequencer
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_UPDATE
   } seq_state_e;

   // Error counter slots
   typedef enum int {
      ERR_LCRC_SEQ,
      ERR_END_LEN,
      ERR_FORM,
      ERR_FC_OVF,
      ERR_ECRC,
      ERR_UNSUP
   } err_kind_e;

   typedef logic [`ERR_CNT_W-1:0] err_count_t;

endpackage

// File: verilog/err_sat_counter.sv
`timescale 1ns/100ps

// ============================================================
// Saturating event counter
// ============================================================
module err_sat_counter #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             inc,
   input  wire logic             clr,
   output logic [WIDTH-1:0]      count
);

   localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
   localparam logic [WIDTH-1:0] TOP = {WIDTH{1'b1}};

   wire logic [WIDTH-1:0] bumped;
   wire logic [WIDTH-1:0] next_count;

   // Saturate rather than wrap so a flood of errors never reads small
   assign bumped     = (count == TOP) ? TOP : count + ONE;
   // An event in the clear cycle still counts as one
   assign next_count = clr ? (inc ? ONE : '0) : (inc ? bumped : count);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule // err_sat_counter

// File: verilog/rx_tlp_test_observer.sv
//
// Contract
// - Provide observation output bus and test control input bus.
// - Observe internal state and keep a separate counter per error type.
// - Outside test logic may force noncompliant behaviour through test-in.
// - Bits 2:0 show header dwords 0-1, dwords 2-3, payload valid.
// - Bits 10:3 check state; bit0 LCRC checked, bit1 LCRC/sequence error.
// - Check bit 2 flags end framing disagreeing with length field.
// - Check bit 3 flags packet breaking formation rules.
// - Check bit 5 flags end-to-end CRC error; credits still updated.
// - Check bit 6 flags unsupported packet; credits updated.
// - Check bit 7 flags configuration-routed packet; credits updated.
// - Check bits 1-4 drop packet from buffer, consume no credits.
// - Check bits 5-7 store first, then route to config, update credits.
// - Bits 13:11 show virtual channel chosen from traffic class.
// - Bit 38 pulse qualifies bits 37:0; valid only while high.
//
`timescale 1ns/100ps
`include "rx_obs_cfg.svh"

module rx_tlp_test_observer #(
   parameter int CNT_W = `ERR_CNT_W
) (
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire logic                   rx_ok_in,
   input  wire logic                   rx_pkt_end,
   input  wire logic                   rx_hdr01_valid,
   input  wire logic                   rx_hdr23_valid,
   input  wire logic                   rx_payload_valid,
   input  wire logic                   rx_lcrc_check,
   input  wire logic                   rx_lcrc_err,
   input  wire logic                   rx_seq_err,
   input  wire logic                   rx_end_len_err,
   input  wire logic                   rx_form_err,
   input  wire logic                   rx_fc_overflow,
   input  wire logic                   rx_ecrc_err,
   input  wire logic                   rx_unsupported,
   input  wire logic                   rx_cfg_route,
   input  wire logic [`TC_W-1:0]       rx_tc,
   input  wire logic [`TC_MAP_W-1:0]   tc_vc_map,
   input  wire logic [`TI_WIDTH-1:0]   test_in,
   output logic [`OBS_WIDTH-1:0]       test_obs,
   output logic                        rx_buf_drop,
   output logic                        rx_buf_store,
   output logic                        cfg_route_req,
   output logic                        fc_credit_update,
   output logic                        force_compliance,
   output logic                        disable_compliance,
   output logic                        remote_boot_en,
   output logic [CNT_W-1:0]            err_cnt_lcrc_seq,
   output logic [CNT_W-1:0]            err_cnt_end_len,
   output logic [CNT_W-1:0]            err_cnt_form,
   output logic [CNT_W-1:0]            err_cnt_fc_ovf,
   output logic [CNT_W-1:0]            err_cnt_ecrc,
   output logic [CNT_W-1:0]            err_cnt_unsup
);

   // ============================================================
   // Helpers
   // ============================================================
   // One 3-bit channel field per traffic class
   function automatic logic [`OBS_VC_W-1:0] vc_of_tc(
      input logic [`TC_MAP_W-1:0] map,
      input logic [`TC_W-1:0]     tc
   );
      vc_of_tc = map[tc*`OBS_VC_W +: `OBS_VC_W];
   endfunction

   function automatic logic any_set(input logic [`OBS_CHK_W-1:0] v,
                                    input int lo,
                                    input int hi);
      logic r;
      r = 1'b0;
      for (int i = 0; i < `OBS_CHK_W; i++) begin
         if (i >= lo && i <= hi) begin
            r = r | v[i];
         end
      end
      any_set = r;
   endfunction

   // ============================================================
   // Test-in decode
   // ============================================================
   wire logic inj_lcrc;
   wire logic inj_ecrc;
   wire logic clr_count;

   assign inj_lcrc  = test_in[`TI_INJ_LCRC];
   assign inj_ecrc  = test_in[`TI_INJ_ECRC];
   assign clr_count = test_in[`TI_CLR_COUNT];

   // ============================================================
   // Check-state assembly
   // ============================================================
   wire logic [`OBS_SEQ_W-1:0] seq_flags;
   wire logic [`OBS_CHK_W-1:0] chk_flags;
   wire logic [`OBS_VC_W-1:0]  rx_channel_map;

   assign seq_flags = {rx_payload_valid, rx_hdr23_valid, rx_hdr01_valid};

   assign chk_flags[`CHK_LCRC_CHECK] = rx_lcrc_check;
   assign chk_flags[`CHK_LCRC_ERR]   = rx_lcrc_err | rx_seq_err | inj_lcrc;
   assign chk_flags[`CHK_END_LEN]    = rx_end_len_err;
   assign chk_flags[`CHK_FORM]       = rx_form_err;
   assign chk_flags[`CHK_FC_OVF]     = rx_fc_overflow;
   assign chk_flags[`CHK_ECRC]       = rx_ecrc_err | inj_ecrc;
   assign chk_flags[`CHK_UNSUP]      = rx_unsupported;
   assign chk_flags[`CHK_CFG]        = rx_cfg_route;

   assign rx_channel_map = vc_of_tc(tc_vc_map, rx_tc);

   // ============================================================
   // Verdict decode
   // ============================================================
   wire logic verdict;
   wire logic drop_pkt;
   wire logic keep_pkt;
   wire logic route_pkt;

   // Verdict only on the qualified end-of-packet cycle
   assign verdict   = rx_ok_in & rx_pkt_end;
   // drop wins over any keep flag
   assign drop_pkt  = verdict & any_set(chk_flags, `CHK_LCRC_ERR, `CHK_FC_OVF);
   assign keep_pkt  = verdict & ~drop_pkt;
   assign route_pkt = any_set(chk_flags, `CHK_ECRC, `CHK_CFG);

   // ============================================================
   // Observation register
   // ============================================================
   wire logic [`OBS_WIDTH-1:0] next_test_obs;

   assign next_test_obs = {rx_ok_in,
                           {`OBS_HI_W{1'b0}},
                           rx_channel_map,
                           chk_flags,
                           seq_flags};

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         test_obs <= `OBS_RESET;
      end else begin
         test_obs <= next_test_obs;
      end
   end

   // ============================================================
   // Buffer and credit sequencer
   // ============================================================
   rx_obs_pkg::seq_state_e state;
   rx_obs_pkg::seq_state_e next_state;
   logic                   route_pend;
   wire logic              in_update;

   assign in_update  = (state == rx_obs_pkg::SEQ_UPDATE);
   // A new keep verdict in the update cycle restarts the pair cleanly
   assign next_state = keep_pkt ? rx_obs_pkg::SEQ_UPDATE
                                : rx_obs_pkg::SEQ_IDLE;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= rx_obs_pkg::SEQ_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         route_pend <= 1'b0;
      end else if (keep_pkt) begin
         route_pend <= route_pkt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rx_buf_drop <= 1'b0;
      end else begin
         rx_buf_drop <= drop_pkt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rx_buf_store     <= 1'b0;
         fc_credit_update <= 1'b0;
         cfg_route_req    <= 1'b0;
      end else begin
         rx_buf_store     <= keep_pkt;
         fc_credit_update <= in_update;
         cfg_route_req    <= in_update & route_pend;
      end
   end

   // ============================================================
   // Test-in mode controls
   // ============================================================
   // noncompliant modes
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         force_compliance   <= 1'b0;
         disable_compliance <= 1'b0;
         remote_boot_en     <= 1'b0;
      end else begin
         // Disable beats force so the two never drive together
         force_compliance   <= test_in[`TI_FORCE_COMPL]
                               & ~test_in[`TI_DIS_COMPL];
         disable_compliance <= test_in[`TI_DIS_COMPL];
         remote_boot_en     <= test_in[`TI_REMOTE_BOOT];
      end
   end

   // ============================================================
   // Per-type error counters
   // ============================================================
   wire logic [`ERR_TYPES-1:0] err_evt;
   wire logic [CNT_W-1:0]      cnt [`ERR_TYPES];

   assign err_evt[rx_obs_pkg::ERR_LCRC_SEQ] =
      verdict & chk_flags[`CHK_LCRC_ERR];
   assign err_evt[rx_obs_pkg::ERR_END_LEN]  =
      verdict & chk_flags[`CHK_END_LEN];
   assign err_evt[rx_obs_pkg::ERR_FORM]     =
      verdict & chk_flags[`CHK_FORM];
   assign err_evt[rx_obs_pkg::ERR_FC_OVF]   =
      verdict & chk_flags[`CHK_FC_OVF];
   assign err_evt[rx_obs_pkg::ERR_ECRC]     =
      verdict & chk_flags[`CHK_ECRC];
   assign err_evt[rx_obs_pkg::ERR_UNSUP]    =
      verdict & chk_flags[`CHK_UNSUP];

   for (genvar g = 0; g < `ERR_TYPES; g++) begin : g_cnt
      err_sat_counter #(
         .WIDTH (CNT_W)
      ) u_cnt (
         .clk_sys (clk_sys),
         .rst_n   (rst_n),
         .inc     (err_evt[g]),
         .clr     (clr_count),
         .count   (cnt[g])
      );
   end

   assign err_cnt_lcrc_seq = cnt[rx_obs_pkg::ERR_LCRC_SEQ];
   assign err_cnt_end_len  = cnt[rx_obs_pkg::ERR_END_LEN];
   assign err_cnt_form     = cnt[rx_obs_pkg::ERR_FORM];
   assign err_cnt_fc_ovf   = cnt[rx_obs_pkg::ERR_FC_OVF];
   assign err_cnt_ecrc     = cnt[rx_obs_pkg::ERR_ECRC];
   assign err_cnt_unsup    = cnt[rx_obs_pkg::ERR_UNSUP];

endmodule // rx_tlp_test_observer

// File: bench/obs_monitor.sv
`timescale 1ns/100ps
`include "rx_obs_cfg.svh"

// ============================================================
// Debug-side monitor
// ============================================================
module obs_monitor (
   input  wire logic [`TI_WIDTH-1:0]   ti_req,
   input  wire logic                   clk_sys,
   input  wire logic [`OBS_WIDTH-1:0]  test_obs,
   output logic [`TI_WIDTH-1:0]        test_in,
   output logic [`OBS_OK_BIT-1:0]      seen
);
   assign test_in = ti_req;

   always_ff @(posedge clk_sys) begin
      if (test_obs[`OBS_OK_BIT])
         seen <= test_obs[`OBS_OK_BIT-1:0];
   end
endmodule // obs_monitor

// File: bench/rx_obs_sva.sv
`timescale 1ns/100ps
`include "rx_obs_cfg.svh"

// ============================================================
// Port checker
// ============================================================
module rx_obs_sva (
   input wire logic                  clk_sys,
   input wire logic                  rst_n,
   input wire logic                  rx_ok_in,
   input wire logic                  rx_pkt_end,
   input wire logic                  rx_hdr01_valid,
   input wire logic                  rx_hdr23_valid,
   input wire logic                  rx_payload_valid,
   input wire logic                  rx_lcrc_check,
   input wire logic                  rx_lcrc_err,
   input wire logic                  rx_seq_err,
   input wire logic                  rx_end_len_err,
   input wire logic                  rx_form_err,
   input wire logic                  rx_fc_overflow,
   input wire logic                  rx_ecrc_err,
   input wire logic                  rx_unsupported,
   input wire logic                  rx_cfg_route,
   input wire logic [`TC_W-1:0]      rx_tc,
   input wire logic [`TC_MAP_W-1:0]  tc_vc_map,
   input wire logic [`TI_WIDTH-1:0]  test_in,
   input wire logic [`OBS_WIDTH-1:0] test_obs,
   input wire logic                  rx_buf_drop,
   input wire logic                  rx_buf_store,
   input wire logic                  cfg_route_req,
   input wire logic                  fc_credit_update
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   wire vd = rx_ok_in & rx_pkt_end;
   wire dr = rx_lcrc_err | rx_seq_err | test_in[0] | rx_end_len_err |
             rx_form_err | rx_fc_overflow;
   wire rt = rx_ecrc_err | test_in[1] | rx_unsupported | rx_cfg_route;

   AST_OK_DELAY: assert property (
      1 |=> test_obs[38] == $past(rx_ok_in))
      else $error("qualifier not a one-cycle copy");
   AST_SEQ: assert property (
      1 |=> test_obs[2:0] ==
         $past({rx_payload_valid, rx_hdr23_valid, rx_hdr01_valid}))
      else $error("sequencing bits wrong");
   AST_LCRC_BIT: assert property (
      1 |=> test_obs[4] == $past(rx_lcrc_err | rx_seq_err | test_in[0]))
      else $error("link crc bit wrong");
   AST_CHK_BYTE: assert property (
      1 |=> test_obs[10:3] == $past({rx_cfg_route, rx_unsupported,
         rx_ecrc_err | test_in[1], rx_fc_overflow, rx_form_err,
         rx_end_len_err, rx_lcrc_err | rx_seq_err | test_in[0],
         rx_lcrc_check}))
      else $error("check byte wrong");
   AST_VC: assert property (
      1 |=> test_obs[13:11] == $past(tc_vc_map[rx_tc*3 +: 3]))
      else $error("channel mapping wrong");
   AST_DROP: assert property (
      vd && dr |=> rx_buf_drop && !rx_buf_store)
      else $error("drop missing");
   AST_NO_CREDIT: assert property (
      vd && dr |-> ##2 !fc_credit_update)
      else $error("credit after drop");
   AST_KEEP: assert property (
      vd && !dr |=> rx_buf_store ##1 fc_credit_update)
      else $error("store then credit missing");
   AST_ROUTE: assert property (
      vd && !dr |-> ##2 cfg_route_req == $past(rt, 2))
      else $error("route request wrong");
   AST_RESET: assert property (
      disable iff (1'b0) !rst_n |=> test_obs == '0 && !rx_buf_store)
      else $error("outputs not cleared in reset");

   COV_DROP: cover property (vd && dr ##1 rx_buf_drop);
   COV_ROUTE: cover property (rx_buf_store ##1 cfg_route_req);
   COV_B2B: cover property (rx_buf_store [*2]);
endmodule // rx_obs_sva

bind rx_tlp_test_observer rx_obs_sva rx_obs_sva_i (.clk_sys, .rst_n,
   .rx_ok_in, .rx_pkt_end, .rx_hdr01_valid, .rx_hdr23_valid,
   .rx_payload_valid, .rx_lcrc_check, .rx_lcrc_err, .rx_seq_err,
   .rx_end_len_err,
   .rx_form_err, .rx_fc_overflow, .rx_ecrc_err, .rx_unsupported,
   .rx_cfg_route, .rx_tc, .tc_vc_map, .test_in, .test_obs, .rx_buf_drop,
   .rx_buf_store, .cfg_route_req, .fc_credit_update);

// File: bench/rx_tlp_test_observer_tb_top.sv
`timescale 1ns/100ps

module rx_tlp_test_observer_tb_top;
   typedef struct packed {
      logic [8:0] f;
      logic [2:0] tc;
      logic [7:0] ti;
      logic [7:0] ck;
      logic [5:0] ef;
   } row_s;

   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [24:0] stim = '0;
   // Reversed map so a wrong slice cannot pass
   logic [23:0] map = 24'h053977;
   logic [38:0] test_obs;
   logic [37:0] seen;
   logic [7:0]  test_in;
   logic [15:0] err_cnt_ecrc;
   logic [15:0] err_cnt_lcrc_seq, err_cnt_end_len, err_cnt_form;
   logic [15:0] err_cnt_fc_ovf, err_cnt_unsup;
   logic        drop, store, route, fc, frc, dis, boot;
   int          fails = 0;
   int          checks_done = 0;
   int          cyc = 0;
   row_s        r;
   // Effects: drop, store, route, force, disable, boot
   row_s rows [16] = '{
      '{9'h001, 3'h0, 8'h00, 8'h01, 6'h10},
      '{9'h002, 3'h1, 8'h00, 8'h02, 6'h20},
      '{9'h004, 3'h2, 8'h00, 8'h02, 6'h20},
      '{9'h008, 3'h3, 8'h00, 8'h04, 6'h20},
      '{9'h010, 3'h4, 8'h00, 8'h08, 6'h20},
      '{9'h020, 3'h5, 8'h00, 8'h10, 6'h20},
      '{9'h040, 3'h6, 8'h00, 8'h20, 6'h18},
      '{9'h080, 3'h7, 8'h00, 8'h40, 6'h18},
      '{9'h100, 3'h0, 8'h00, 8'h80, 6'h18},
      '{9'h000, 3'h1, 8'h01, 8'h02, 6'h20},
      '{9'h000, 3'h2, 8'h02, 8'h20, 6'h18},
      '{9'h000, 3'h3, 8'h04, 8'h00, 6'h14},
      '{9'h000, 3'h4, 8'h08, 8'h00, 6'h12},
      '{9'h000, 3'h5, 8'h0C, 8'h00, 6'h12},
      '{9'h000, 3'h6, 8'h10, 8'h00, 6'h11},
      '{9'h042, 3'h7, 8'h00, 8'h22, 6'h20}};

   always #5 clk_sys = ~clk_sys;

   rx_tlp_test_observer rx_tlp_test_observer_i (.clk_sys(clk_sys),
      .rst_n(rst_n), .rx_ok_in(stim[24]), .rx_pkt_end(stim[23]),
      .rx_cfg_route(stim[22]), .rx_unsupported(stim[21]),
      .rx_ecrc_err(stim[20]), .rx_fc_overflow(stim[19]),
      .rx_form_err(stim[18]), .rx_end_len_err(stim[17]),
      .rx_seq_err(stim[16]), .rx_lcrc_err(stim[15]),
      .rx_lcrc_check(stim[14]), .rx_payload_valid(stim[13]),
      .rx_hdr23_valid(stim[12]), .rx_hdr01_valid(stim[11]),
      .rx_tc(stim[10:8]), .tc_vc_map(map), .test_in(test_in),
      .test_obs(test_obs), .rx_buf_drop(drop), .rx_buf_store(store),
      .cfg_route_req(route), .fc_credit_update(fc),
      .force_compliance(frc), .disable_compliance(dis),
      .remote_boot_en(boot), .err_cnt_lcrc_seq(err_cnt_lcrc_seq),
      .err_cnt_end_len(err_cnt_end_len), .err_cnt_form(err_cnt_form),
      .err_cnt_fc_ovf(err_cnt_fc_ovf), .err_cnt_ecrc(err_cnt_ecrc),
      .err_cnt_unsup(err_cnt_unsup));

   obs_monitor obs_monitor_i (.ti_req(stim[7:0]), .clk_sys(clk_sys),
      .test_obs(test_obs), .test_in(test_in), .seen(seen));

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // One-cycle request, then idle
   task automatic send(input logic [24:0] v);
      @(posedge clk_sys) stim <= v;
      @(posedge clk_sys) stim <= '0;
      #1;
   endtask

   task final_report;
      $display("checks=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Hang guard, run needs well under 200 cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 1000) begin
         fails++;
         final_report();
      end
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      #1 chk({test_obs, err_cnt_ecrc}, '0);
      @(posedge clk_sys) rst_n <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         r = rows[i];
         send({2'b11, r.f, i[2:0], r.tc, r.ti});
         chk(test_obs[38], 1'b1);
         chk({drop, store, frc, dis, boot}, {r.ef[5:4], r.ef[2:0]});
         @(posedge clk_sys) #1;
         chk(seen, {24'h0, map[r.tc*3 +: 3], r.ck, i[2:0]});
         chk({route, fc}, {r.ef[3], r.ef[4]});
      end
      // Flags without a verdict must not act
      send({2'b10, 9'h002, 14'h0000});
      chk({drop, store, test_obs[4]}, 3'b001);
      chk({err_cnt_lcrc_seq, err_cnt_end_len}, 32'h0004_0001);
      chk({err_cnt_form, err_cnt_fc_ovf}, 32'h0001_0001);
      chk({err_cnt_unsup, err_cnt_ecrc}, 32'h0001_0003);
      // Clear, then back-to-back kept packets, the first one with clear
      @(posedge clk_sys) stim <= 25'h20;
      @(posedge clk_sys) stim <= {2'b11, 9'h040, 14'h0020};
      @(posedge clk_sys) stim <= {2'b11, 9'h040, 14'h0000};
      @(posedge clk_sys) stim <= '0;
      #1 chk({store, fc}, 2'b11);
      chk(err_cnt_ecrc, 16'h0002);
      chk({err_cnt_lcrc_seq, err_cnt_unsup}, 32'h0);
      @(posedge clk_sys) #1;
      chk({store, fc, route}, 3'b011);
      // Reset in mid-packet
      @(posedge clk_sys) stim <= {2'b11, 9'h040, 14'h0000};
      @(posedge clk_sys) rst_n <= 1'b0;
      stim <= '0;
      @(posedge clk_sys) #1;
      chk({test_obs, store, fc, err_cnt_ecrc}, '0);
      @(posedge clk_sys) rst_n <= 1'b1;
      // First packet after the second release
      send({2'b11, 9'h002, 14'h0000});
      chk(test_obs[38], 1'b1);
      chk({drop, store, err_cnt_lcrc_seq}, 18'h2_0001);
      final_report();
   end
endmodule // rx_tlp_test_observer_tb_top
